// ---- inc/usb_xcvr_ctl_pkg.sv ----
// constants for the usb transceiver control block: register map, fields, line codes
// assumes a 32-bit apb with byte addresses and one aligned word per register
package usb_xcvr_ctl_pkg;
   // ************************************************************
   // register offsets
   // ************************************************************
   localparam logic [7:0] ctl_off = 8'h40;
   localparam logic [7:0] irq_sts_off = 8'h44;
   localparam logic [7:0] irq_clr_off = 8'h48;
   localparam logic [7:0] irq_en_off = 8'h4c;
   // ************************************************************
   // control register fields
   // ************************************************************
   localparam int pd_dis_bit = 18;
   localparam int rst_cause_bit = 13;
   localparam int res_cause_bit = 12;
   localparam int filt_lo = 8;
   localparam int auto_res_bit = 7;
   localparam int conf_lo = 4;
   localparam logic pd_dis_rst = 1'b0;
   localparam logic [3:0] filt_rst = 4'h0;
   localparam logic auto_res_rst = 1'b0;
   localparam logic [2:0] conf_rst = 3'h0;
   // ************************************************************
   // interrupt status bits
   // ************************************************************
   localparam int ev_rst_bit = 0;
   localparam int ev_res_bit = 1;
   localparam int ev_ls_bit = 2;
   localparam int ev_w = 3;
   // ************************************************************
   // full-speed line state codes
   // ************************************************************
   localparam logic [1:0] ls_se0 = 2'h0;
   localparam logic [1:0] ls_j = 2'h1;
   localparam logic [1:0] ls_k = 2'h2;
endpackage

// ---- rtl/usb_xcvr_ctl.sv ----
// control register between the usb interface unit and its transceiver, with line filter,
// suspend resume control and an interrupt set. assumes an apb master on the same clock.
// Notes on behaviour
// R1: writing 1 to the pull-down disable bit turns off the transceiver pull-downs.
// R2: an automatic resume caused by se0 sets the reset-cause flag until software writes 0.
// R3: an automatic resume caused by k sets the resume-cause flag until software writes 0.
// R4: each line state change is held 2 to the power n clocks before it passes on.
// R5: with auto-resume set hardware resumes from suspend, otherwise software polls.
// R6: the three config pins follow the three-bit config field and reset low.
// R7: reserved control bits read zero and ignore writes.
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
module usb_xcvr_ctl #(
   parameter int max_log2 = 15
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [1:0] line_state,
   input wire logic suspend_req,
   output logic [1:0] line_state_filt,
   output logic resume_pulse,
   output logic pulldown_dis,
   output logic [2:0] transceiver_config_pins,
   output logic irq
);
   // ************************************************************
   // elaboration check
   // ************************************************************
   if (max_log2 < 1 || max_log2 > 15) begin : g_bad
      $error("max_log2 must lie in 1..15");
   end

   typedef enum logic [2:0] {
      st_awake = 3'h1,
      st_susp = 3'h2,
      st_wake = 3'h4
   } susp_t;

   // ************************************************************
   // state
   // ************************************************************
   logic pd_dis_r;
   logic rst_cause_r;
   logic res_cause_r;
   logic [3:0] filt_r;
   logic auto_res_r;
   logic [2:0] conf_r;
   logic [usb_xcvr_ctl_pkg::ev_w-1:0] sts_r;
   logic [usb_xcvr_ctl_pkg::ev_w-1:0] en_r;
   logic [1:0] ls_m_r;
   logic [1:0] ls_s_r;
   logic [1:0] cand_r;
   logic [1:0] lsf_r;
   logic [15:0] cnt_r;
   susp_t st_r;
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;
   logic resume_r;
   logic irq_r;

   // ************************************************************
   // apb decode
   // ************************************************************
   wire setup = psel && !penable;
   wire acc = psel && penable && pready_r;
   wire wr = acc && pwrite;
   wire hit_ctl = paddr == usb_xcvr_ctl_pkg::ctl_off;
   wire hit_sts = paddr == usb_xcvr_ctl_pkg::irq_sts_off;
   wire hit_clr = paddr == usb_xcvr_ctl_pkg::irq_clr_off;
   wire hit_en = paddr == usb_xcvr_ctl_pkg::irq_en_off;
   wire mapped = hit_ctl || hit_sts || hit_clr || hit_en;
   wire wr_ctl = wr && hit_ctl;
   // reserved bits are simply not stored, so they read zero
   wire [31:0] ctl_rd = {13'h0000, pd_dis_r, 4'h0, rst_cause_r, res_cause_r, filt_r,
                         auto_res_r, conf_r, 4'h0}; // R7
   wire [31:0] rd_mux = hit_ctl ? ctl_rd :
                        hit_sts ? {29'h0, sts_r} :
                        hit_en ? {29'h0, en_r} : 32'h0000_0000;

   // ************************************************************
   // line state filter
   // ************************************************************
   // pass count: 2**n cycles of a steady candidate before it is accepted
   wire [15:0] target = 16'h0001 << filt_r;
   wire cand_new = ls_s_r != cand_r;
   wire cand_take = !cand_new && (cand_r != lsf_r) && (cnt_r >= target - 16'h0001);
   wire ls_evt = cand_take;

   // ************************************************************
   // suspend controller
   // ************************************************************
   wire wake_seen = (lsf_r == usb_xcvr_ctl_pkg::ls_se0) || (lsf_r == usb_xcvr_ctl_pkg::ls_k);
   wire res_done = (st_r == st_wake);
   wire done_se0 = res_done && (lsf_r == usb_xcvr_ctl_pkg::ls_se0);
   wire done_k = res_done && (lsf_r == usb_xcvr_ctl_pkg::ls_k);
   susp_t st_nxt;
   always_comb begin
      st_nxt = st_r;
      unique case (st_r)
         st_awake: begin
            if (suspend_req) begin
               st_nxt = st_susp;
            end
         end
         st_susp: begin
            // without auto-resume the state waits for software to drop the request
            if (!suspend_req) begin
               st_nxt = st_awake;
            end else if (auto_res_r && wake_seen) begin
               st_nxt = st_wake; // R5
            end
         end
         st_wake: begin
            st_nxt = st_awake;
         end
         default: begin
            st_nxt = st_awake;
         end
      endcase
   end

   // ************************************************************
   // interrupt status next values
   // ************************************************************
   wire [usb_xcvr_ctl_pkg::ev_w-1:0] ev = {ls_evt, done_k, done_se0};
   wire [usb_xcvr_ctl_pkg::ev_w-1:0] clr_m = (wr && hit_clr) ?
                                             pwdata[usb_xcvr_ctl_pkg::ev_w-1:0] : '0;
   // set beats a clear arriving in the same cycle
   wire [usb_xcvr_ctl_pkg::ev_w-1:0] sts_nxt = (sts_r & ~clr_m) | ev;
   wire [usb_xcvr_ctl_pkg::ev_w-1:0] en_nxt = (wr && hit_en) ?
                                             pwdata[usb_xcvr_ctl_pkg::ev_w-1:0] : en_r;

   // cause flags: software clears with a 0, a new cause wins over that write
   wire rst_cause_nxt = done_se0 ||
                        (rst_cause_r && !(wr_ctl && !pwdata[usb_xcvr_ctl_pkg::rst_cause_bit]));
   wire res_cause_nxt = done_k ||
                        (res_cause_r && !(wr_ctl && !pwdata[usb_xcvr_ctl_pkg::res_cause_bit]));

   // ************************************************************
   // apb answer registers
   // ************************************************************
   // zero wait: ready is registered from the setup cycle, so the access phase is one cycle
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
      end else begin
         pready_r <= setup;
         pslverr_r <= setup && !mapped;
         prdata_r <= (setup && !pwrite) ? rd_mux : 32'h0000_0000;
      end
   end

   // ************************************************************
   // control register
   // ************************************************************
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pd_dis_r <= usb_xcvr_ctl_pkg::pd_dis_rst;
         filt_r <= usb_xcvr_ctl_pkg::filt_rst;
         auto_res_r <= usb_xcvr_ctl_pkg::auto_res_rst;
         conf_r <= usb_xcvr_ctl_pkg::conf_rst;
      end else if (wr_ctl) begin
         pd_dis_r <= pwdata[usb_xcvr_ctl_pkg::pd_dis_bit]; // R1
         filt_r <= pwdata[usb_xcvr_ctl_pkg::filt_lo +: 4]; // R4
         auto_res_r <= pwdata[usb_xcvr_ctl_pkg::auto_res_bit]; // R5
         conf_r <= pwdata[usb_xcvr_ctl_pkg::conf_lo +: 3]; // R6
      end
   end

   // cause flags and interrupt registers
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rst_cause_r <= 1'b0;
         res_cause_r <= 1'b0;
         sts_r <= '0;
         en_r <= '0;
         irq_r <= 1'b0;
      end else begin
         rst_cause_r <= rst_cause_nxt; // R2
         res_cause_r <= res_cause_nxt; // R3
         sts_r <= sts_nxt;
         en_r <= en_nxt;
         irq_r <= |(sts_nxt & en_nxt);
      end
   end

   // line synchroniser and filter
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ls_m_r <= usb_xcvr_ctl_pkg::ls_j;
         ls_s_r <= usb_xcvr_ctl_pkg::ls_j;
         cand_r <= usb_xcvr_ctl_pkg::ls_j;
         lsf_r <= usb_xcvr_ctl_pkg::ls_j;
         cnt_r <= 16'h0000;
      end else begin
         ls_m_r <= line_state;
         ls_s_r <= ls_m_r;
         if (cand_new) begin
            cand_r <= ls_s_r;
            cnt_r <= 16'h0000;
         end else if (cand_take) begin
            lsf_r <= cand_r; // R4
            cnt_r <= 16'h0000;
         end else if (cand_r != lsf_r) begin
            cnt_r <= cnt_r + 16'h0001;
         end
      end
   end

   // suspend state and resume strobe
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= st_awake;
         resume_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         resume_r <= (st_nxt == st_wake); // R5
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign line_state_filt = lsf_r;
   assign resume_pulse = resume_r;
   assign pulldown_dis = pd_dis_r; // R1
   assign transceiver_config_pins = conf_r; // R6
   assign irq = irq_r;

   // ************************************************************
   // assertion helpers
   // ************************************************************
   // age of the synchronised line value, kept apart from the filter so its timing is judged
   logic [1:0] ls_d_r;
   logic [16:0] age_r;
   wire [16:0] hold_min = 17'h00001 << filt_r;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ls_d_r <= usb_xcvr_ctl_pkg::ls_j;
         age_r <= 17'h00000;
      end else begin
         ls_d_r <= ls_s_r;
         if (ls_s_r != ls_d_r) begin
            age_r <= 17'h00000;
         end else if (age_r != 17'h1ffff) begin
            age_r <= age_r + 17'h00001; // saturates so a long idle never wraps to young
         end
      end
   end

   // ************************************************************
   // assertions
   // ************************************************************
   a_pulldown_follow: assert property (@(posedge clock) disable iff (!rst_n) // R1
      wr_ctl |=> pulldown_dis == $past(pwdata[usb_xcvr_ctl_pkg::pd_dis_bit]))
      else $error("pull-down disable does not follow write");
   a_rst_cause_set: assert property (@(posedge clock) disable iff (!rst_n) // R2
      done_se0 |=> rst_cause_r)
      else $error("reset cause not set after se0 resume");
   a_rst_cause_hold: assert property (@(posedge clock) disable iff (!rst_n) // R2
      rst_cause_r && !wr_ctl |=> rst_cause_r)
      else $error("reset cause dropped without a write");
   a_res_cause_set: assert property (@(posedge clock) disable iff (!rst_n) // R3
      done_k ##1 !wr_ctl |-> res_cause_r)
      else $error("resume cause not set after k resume");
   a_filter_hold: assert property (@(posedge clock) disable iff (!rst_n) // R4
      $changed(lsf_r) |-> lsf_r == ls_d_r && age_r >= $past(hold_min))
      else $error("filtered line state changed too early");
   a_no_auto_wake: assert property (@(posedge clock) disable iff (!rst_n) // R5
      !auto_res_r && st_r == st_susp |=> !resume_pulse)
      else $error("hardware resumed while auto-resume off");
   a_auto_wake: assert property (@(posedge clock) disable iff (!rst_n) // R5
      st_r == st_susp && auto_res_r && wake_seen && suspend_req |=> resume_pulse ##1 !resume_pulse)
      else $error("auto resume did not pulse once");
   a_config_pins: assert property (@(posedge clock) disable iff (!rst_n) // R6
      wr_ctl |=> transceiver_config_pins == $past(pwdata[usb_xcvr_ctl_pkg::conf_lo +: 3]))
      else $error("config pins differ from written field");
   a_config_hold: assert property (@(posedge clock) disable iff (!rst_n) // R6
      !wr_ctl |=> $stable(transceiver_config_pins))
      else $error("config pins moved without a write");
   a_pulldown_hold: assert property (@(posedge clock) disable iff (!rst_n) // R1
      !wr_ctl |=> $stable(pulldown_dis))
      else $error("pull-down disable moved without a write");
   a_res_cause_hold: assert property (@(posedge clock) disable iff (!rst_n) // R3
      res_cause_r && !wr_ctl |=> res_cause_r)
      else $error("resume cause dropped without a write");
   a_rst_status: assert property (@(posedge clock) disable iff (!rst_n) // R2
      done_se0 |=> sts_r[usb_xcvr_ctl_pkg::ev_rst_bit])
      else $error("se0 resume did not raise its status bit");
   a_res_status: assert property (@(posedge clock) disable iff (!rst_n) // R3
      done_k |=> sts_r[usb_xcvr_ctl_pkg::ev_res_bit])
      else $error("k resume did not raise its status bit");
   a_reserved_zero: assert property (@(posedge clock) disable iff (!rst_n) // R7
      pready && hit_ctl && !pwrite |-> (prdata & 32'hfffb_c00f) == 32'h0000_0000)
      else $error("reserved control bits read non-zero");
   c_se0_resume: cover property (@(posedge clock) disable iff (!rst_n) done_se0);
   c_k_resume: cover property (@(posedge clock) disable iff (!rst_n) done_k);
   c_irq_raise: cover property (@(posedge clock) disable iff (!rst_n) $rose(irq));
   c_line_accept: cover property (@(posedge clock) disable iff (!rst_n) ls_evt);
   c_poll_wake: cover property (@(posedge clock) disable iff (!rst_n)
      !auto_res_r && st_r == st_susp && wake_seen);
endmodule // usb_xcvr_ctl

// ---- dv/usb_line_model.sv ----
// line model for the transceiver side: presents the full-speed line state
// assumes the bench calls put() from its own thread, one change per call
`timescale 1ns/1ps
module usb_line_model (
   input wire logic clock,
   output logic [1:0] line_state
);
   // idle is j: the pull-up on the bus holds it there until the first call
   initial begin
      line_state = usb_xcvr_ctl_pkg::ls_j;
   end
   // change only just after an edge so the two-flop sync sees a clean step
   task automatic put(input logic [1:0] s);
      @(posedge clock);
      line_state <= s;
   endtask
endmodule // usb_line_model

// ---- dv/tb_top.sv ----
// self-checking bench for the usb transceiver control block
// assumes apb with zero wait states may come, but always waits for pready
`timescale 1ns/1ps
module tb_top;
   localparam logic [7:0] ctl = usb_xcvr_ctl_pkg::ctl_off;
   localparam logic [7:0] sts = usb_xcvr_ctl_pkg::irq_sts_off;
   localparam logic [7:0] clr = usb_xcvr_ctl_pkg::irq_clr_off;
   localparam logic [7:0] ien = usb_xcvr_ctl_pkg::irq_en_off;
   localparam logic [1:0] lj = usb_xcvr_ctl_pkg::ls_j;
   localparam logic [1:0] lk = usb_xcvr_ctl_pkg::ls_k;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic suspend_req = 1'b0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, resume_pulse, pulldown_dis, irq, err;
   logic [1:0] line_state, filt;
   logic [2:0] pins;
   int fail_count = 0;
   int tests_run = 0;
   int cycles = 0;
   initial begin
      forever #4 clock = ~clock;
   end
   usb_xcvr_ctl #(.max_log2(15)) DUT (.clock(clock), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .line_state(line_state),
      .suspend_req(suspend_req), .line_state_filt(filt), .resume_pulse(resume_pulse),
      .pulldown_dis(pulldown_dis), .transceiver_config_pins(pins), .irq(irq));
   usb_line_model line_m (.clock(clock), .line_state(line_state));
   // ************************************************************
   // helpers
   // ************************************************************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask
   // hold the whole request until pready is seen high, then let go
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1) @(posedge clock);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic t_reset;
      apb(1'b0, ctl, 32'h0);
      chk(rd, 32'h0);
      chk({29'h0, pins}, 32'h0);
      chk({31'h0, pulldown_dis}, 32'h0);
      chk({30'h0, filt}, {30'h0, lj});
   endtask
   // ones everywhere: cause flags must ignore a written 1, reserved bits stay 0
   task automatic t_fields;
      apb(1'b1, ctl, 32'hffff_ffff);
      cyc(2);
      chk({31'h0, pulldown_dis}, 32'h1);
      chk({29'h0, pins}, 32'h7);
      apb(1'b0, ctl, 32'h0);
      chk(rd, 32'h0004_0ff0);
      apb(1'b1, ctl, 32'h0000_0050);
      cyc(2);
      chk({29'h0, pins}, 32'h5);
      chk({31'h0, pulldown_dis}, 32'h0);
   endtask
   // n = 2: a three-cycle glitch is dropped, a held k passes after 2^n
   task automatic t_filter;
      apb(1'b1, ctl, 32'h0000_0200);
      line_m.put(lk);
      cyc(2);
      line_m.put(lj);
      cyc(12);
      chk({30'h0, filt}, {30'h0, lj});
      line_m.put(lk);
      cyc(6);
      chk({30'h0, filt}, {30'h0, lj});
      cyc(2);
      chk({30'h0, filt}, {30'h0, lk});
      apb(1'b0, sts, 32'h0);
      chk(rd & 32'h4, 32'h4);
      line_m.put(lj);
      cyc(12);
      apb(1'b1, clr, 32'h7);
   endtask
   task automatic t_auto(input logic [1:0] s, input logic [31:0] flag, input logic [31:0] ev);
      int n = 0;
      apb(1'b1, ctl, 32'h80);
      apb(1'b1, ien, ev);
      suspend_req <= 1'b1;
      cyc(2);
      line_m.put(s);
      while (resume_pulse !== 1'b1 && n < 40) begin
         cyc(1);
         n++;
      end
      chk({31'h0, resume_pulse}, 32'h1);
      suspend_req <= 1'b0;
      line_m.put(lj);
      cyc(3);
      apb(1'b0, ctl, 32'h0);
      chk(rd, 32'h80 | flag);
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, ctl, 32'h80);
      apb(1'b0, ctl, 32'h0);
      chk(rd, 32'h80);
      apb(1'b0, sts, 32'h0);
      chk(rd & 32'h3, ev);
      apb(1'b1, clr, 32'h7);
      cyc(2);
      chk({31'h0, irq}, 32'h0);
   endtask
   // hardware resume off: software has to see k on the filtered line itself
   task automatic t_poll;
      int hits = 0;
      apb(1'b1, ctl, 32'h0);
      suspend_req <= 1'b1;
      line_m.put(lk);
      repeat (20) begin
         @(posedge clock);
         if (resume_pulse === 1'b1) hits++;
      end
      chk(hits, 0);
      chk({30'h0, filt}, {30'h0, lk});
      suspend_req <= 1'b0;
      line_m.put(lj);
      cyc(4);
   endtask
   task automatic t_unmapped;
      apb(1'b1, 8'h50, 32'hffff_ffff);
      chk({31'h0, err}, 32'h1);
      apb(1'b0, 8'h50, 32'h0);
      chk(rd, 32'h0);
      chk({31'h0, err}, 32'h1);
   endtask
   task automatic stop_test;
      if (fail_count == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // hang guard: far above the few hundred cycles the sequence needs
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         fail_count++;
         stop_test;
      end
   end
   initial begin
      cyc(8);
      rst_n <= 1'b1;
      t_reset;
      t_fields;
      t_filter;
      t_auto(usb_xcvr_ctl_pkg::ls_se0, 32'h2000, 32'h1);
      t_auto(lk, 32'h1000, 32'h2);
      t_poll;
      t_unmapped;
      stop_test;
   end
endmodule // tb_top
